// ---- hdl/tdp_pkg.sv ----
// Shared constants and types of the ten-bit down timer with PWM
package tdp_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] ADDR_COUNT  = 8'h10;
    localparam logic [7:0] ADDR_CTL1   = 8'h11;
    localparam logic [7:0] ADDR_CTL2   = 8'h12;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_MASK   = 8'h19;

    // ************************************************************
    // Widths and values
    // ************************************************************
    localparam int         CNT_W        = 10;
    localparam int         PS_W         = 8;
    localparam int         PS_SEL_W     = 3;
    localparam logic [9:0] CNT_MAX      = 10'h03FF;
    localparam logic [9:0] CNT_ZERO     = 10'h0000;
    localparam logic [7:0] PS_INIT      = 8'hFF;
    localparam logic [7:0] CTL1_RST     = 8'h00;
    localparam logic [7:0] CTL2_RST     = 8'h3F;
    localparam logic [7:0] STATUS_RST   = 8'h00;
    localparam logic [7:0] MASK_RST     = 8'h00;
    localparam logic [7:0] BYTE_ZERO    = 8'h00;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int HB_RELOAD_LSB = 4;
    localparam int HB_DUTY_LSB   = 0;
    localparam int IRQ_UNDERFLOW = 0;

    // Control one: PWM enable and polarity, mode bits, timer enable
    typedef struct packed {
        logic       pwm_output_enable_bit;
        logic       pwm_polarity_bit;
        logic [2:0] rsv;
        logic       one_shot_bit;
        logic       reload_select_bit;
        logic       timer_enable_bit;
    } tdp_ctl1_t;

    // Control two: clock source, edge, prescaler switch and ratio
    typedef struct packed {
        logic [1:0] rsv;
        logic       clock_source_bit;
        logic       ext_clock_edge_bit;
        logic       prescaler_disable_n;
        logic [2:0] prescaler_ratio_field;
    } tdp_ctl2_t;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } tdp_bus_req_t;

endpackage

// ---- hdl/tdp_prescaler.sv ----
// Power-of-two prescaler for the timer tick
`timescale 1ns/1ps
module tdp_prescaler #(
    parameter int PS_W = tdp_pkg::PS_W
) (
    input  wire logic                         clk_i,
    input  wire logic                         rst_i,
    input  wire logic                         enable_i,
    input  wire logic [tdp_pkg::PS_SEL_W-1:0] ratio_i,
    input  wire logic                         tick_i,
    output logic                              tick_o
);

    // ************************************************************
    // Elaboration check
    // ************************************************************
    if (PS_W != (1 << tdp_pkg::PS_SEL_W)) begin : g_chk
        $error("prescaler width must match its ratio field");
    end

    logic [PS_W-1:0] cnt_q;
    logic [PS_W-1:0] cnt_d;
    logic [PS_W-1:0] mask;

    // Low bits that must all be zero for a pass-through tick
    for (genvar i = 0; i < PS_W; i++) begin : g_mask
        assign mask[i] = (tdp_pkg::PS_SEL_W'(i) <= ratio_i);
    end

    // Divide by two to the power ratio plus one; bypass when off
    always_comb begin
        cnt_d  = cnt_q;
        tick_o = tick_i;
        if (!enable_i) begin
            cnt_d = tdp_pkg::PS_INIT;
        end else begin
            tick_o = tick_i && ((cnt_q & mask) == '0);
            if (tick_i) begin
                cnt_d = cnt_q - 1'b1;
            end
        end
    end

    // Prescaler count register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= tdp_pkg::PS_INIT;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule

// ---- hdl/tdp_pwm.sv ----
// PWM compare and pin multiplexer
`timescale 1ns/1ps
module tdp_pwm #(
    parameter int CNT_W = tdp_pkg::CNT_W
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [CNT_W-1:0] count_i,
    input  wire logic [CNT_W-1:0] duty_i,
    input  wire logic             polarity_i,
    input  wire logic             output_enable_i,
    input  wire logic             gpio_out_i,
    input  wire logic             gpio_oe_n_i,
    output logic                  pin_o,
    output logic                  pin_oe_n_o
);

    logic pin_q;
    logic pin_d;
    logic oe_n_q;
    logic oe_n_d;
    logic active;

    // Active for the last duty counts of each period
    assign active = (count_i < duty_i);

    // Polarity and ownership of the port pin
    always_comb begin
        pin_d  = gpio_out_i;
        oe_n_d = gpio_oe_n_i;
        if (output_enable_i) begin
            pin_d  = active ^ polarity_i;
            oe_n_d = 1'b0;
        end
    end

    // Registered pin drive avoids glitches from the compare
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_q  <= 1'b0;
            oe_n_q <= 1'b1;
        end else begin
            pin_q  <= pin_d;
            oe_n_q <= oe_n_d;
        end
    end

    assign pin_o      = pin_q;
    assign pin_oe_n_o = oe_n_q;

endmodule

// ---- hdl/tdp_timer.sv ----
// Ten-bit down timer with prescaler, reload modes, PWM and interrupt
`timescale 1ns/1ps
module tdp_timer #(
    parameter int CNT_W = tdp_pkg::CNT_W
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    input  wire logic       instr_tick_i,
    input  wire logic       external_clock_pin_i,
    input  wire logic [7:0] high_bits_register_i,
    input  wire logic [7:0] pwm_duty_register_i,
    input  wire logic       gpio_out_i,
    input  wire logic       gpio_oe_n_i,
    output logic            pwm_port_pin_o,
    output logic            pwm_port_pin_oe_n_o,
    output logic            underflow_o,
    output logic            irq_o
);

    // ************************************************************
    // Elaboration check
    // ************************************************************
    if (CNT_W != tdp_pkg::CNT_W) begin : g_chk
        $error("counter width is fixed at ten bits");
    end

    // ************************************************************
    // Declarations
    // ************************************************************
    tdp_pkg::tdp_bus_req_t req;
    tdp_pkg::tdp_ctl1_t    ctl1_q;
    tdp_pkg::tdp_ctl1_t    ctl1_d;
    tdp_pkg::tdp_ctl2_t    ctl2_q;
    tdp_pkg::tdp_ctl2_t    ctl2_d;
    logic [CNT_W-1:0]      cnt_q;
    logic [CNT_W-1:0]      cnt_d;
    logic [CNT_W-1:0]      reload_q;
    logic [CNT_W-1:0]      reload_d;
    logic                  done_q;
    logic                  done_d;
    logic                  ext_q;
    logic                  ext_d;
    logic                  primed_q;
    logic                  primed_d;
    logic [7:0]            status_q;
    logic [7:0]            status_d;
    logic [7:0]            mask_q;
    logic [7:0]            mask_d;
    logic [7:0]            rdata_q;
    logic [7:0]            rdata_d;
    logic                  ext_rise;
    logic                  ext_fall;
    logic                  src_tick;
    logic                  cnt_tick;
    logic                  run;
    logic                  underflow;
    logic                  wr_count;
    logic [CNT_W-1:0]      write_value;
    logic [CNT_W-1:0]      duty;

    assign req.addr  = addr_i;
    assign req.wdata = wdata_i;
    assign req.wr    = wr_i;
    assign req.rd    = rd_i;

    // ************************************************************
    // Clock source selection
    // ************************************************************

    // Pin is synchronous already, so one stage suffices for edges.
    // Until the first sample after reset the previous level is not
    // known, so no edge is reported in that cycle; otherwise a pin
    // that idles high would count a false rising edge after reset.
    always_comb begin
        ext_d    = external_clock_pin_i;
        primed_d = 1'b1;
    end

    // Edge strobes, each at most one cycle long
    assign ext_rise = primed_q && external_clock_pin_i && !ext_q;
    assign ext_fall = primed_q && !external_clock_pin_i && ext_q;

    // Previous pin level and the primed flag
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ext_q    <= 1'b0;
            primed_q <= 1'b0;
        end else begin
            ext_q    <= ext_d;
            primed_q <= primed_d;
        end
    end

    // Source and edge choice ahead of the prescaler
    always_comb begin
        src_tick = instr_tick_i;
        if (ctl2_q.clock_source_bit) begin
            src_tick = ctl2_q.ext_clock_edge_bit ? ext_fall : ext_rise;
        end
    end

    // Prescaler stage; the low-active switch enables it when zero
    tdp_prescaler #(
        .PS_W (tdp_pkg::PS_W)
    ) u_prescaler (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .enable_i (!ctl2_q.prescaler_disable_n),
        .ratio_i  (ctl2_q.prescaler_ratio_field),
        .tick_i   (src_tick),
        .tick_o   (cnt_tick)
    );

    // ************************************************************
    // Down counter
    // ************************************************************

    // A finished one-shot holds until software rewrites the count
    assign run       = ctl1_q.timer_enable_bit && !done_q;
    assign underflow = run && cnt_tick && (cnt_q == tdp_pkg::CNT_ZERO);
    assign wr_count  = req.wr && (req.addr == tdp_pkg::ADDR_COUNT);

    // Written byte joined with the upper reload bits
    assign write_value = {high_bits_register_i[tdp_pkg::HB_RELOAD_LSB +: 2], req.wdata};

    // Next counter value; a software write wins over a tick
    always_comb begin
        cnt_d    = cnt_q;
        reload_d = reload_q;
        done_d   = done_q;
        if (wr_count) begin
            reload_d = write_value;
            cnt_d    = write_value;
            done_d   = 1'b0;
        end else if (underflow) begin
            if (ctl1_q.one_shot_bit) begin
                done_d = 1'b1;
            end else if (ctl1_q.reload_select_bit) begin
                cnt_d = reload_q;
            end else begin
                cnt_d = tdp_pkg::CNT_MAX;
            end
        end else if (run && cnt_tick) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    // Counter and reload registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q    <= tdp_pkg::CNT_ZERO;
            reload_q <= tdp_pkg::CNT_ZERO;
            done_q   <= 1'b0;
        end else begin
            cnt_q    <= cnt_d;
            reload_q <= reload_d;
            done_q   <= done_d;
        end
    end

    // ************************************************************
    // Control registers and interrupt
    // ************************************************************

    // Control writes; ratio changes while the prescaler runs are
    // accepted as is, a stray tick is the price software pays
    always_comb begin
        ctl1_d = ctl1_q;
        ctl2_d = ctl2_q;
        mask_d = mask_q;
        if (req.wr && (req.addr == tdp_pkg::ADDR_CTL1)) begin
            ctl1_d     = tdp_pkg::tdp_ctl1_t'(req.wdata);
            ctl1_d.rsv = '0;
        end
        if (req.wr && (req.addr == tdp_pkg::ADDR_CTL2)) begin
            ctl2_d     = tdp_pkg::tdp_ctl2_t'(req.wdata);
            ctl2_d.rsv = '0;
        end
        if (req.wr && (req.addr == tdp_pkg::ADDR_MASK)) begin
            mask_d = req.wdata;
        end
    end

    // Sticky status: write one clears, a new underflow wins
    always_comb begin
        status_d = status_q;
        if (req.wr && (req.addr == tdp_pkg::ADDR_STATUS)) begin
            status_d = status_q & ~req.wdata;
        end
        if (underflow) begin
            status_d[tdp_pkg::IRQ_UNDERFLOW] = 1'b1;
        end
    end

    // Control and mask registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctl1_q   <= tdp_pkg::tdp_ctl1_t'(tdp_pkg::CTL1_RST);
            ctl2_q   <= tdp_pkg::tdp_ctl2_t'(tdp_pkg::CTL2_RST);
            mask_q   <= tdp_pkg::MASK_RST;
        end else begin
            ctl1_q   <= ctl1_d;
            ctl2_q   <= ctl2_d;
            mask_q   <= mask_d;
        end
    end

    // Status register kept apart from the control bytes, so the flag
    // and its clear-and-set priority form one group with the logic
    // above that decides them
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            status_q <= tdp_pkg::STATUS_RST;
        end else begin
            status_q <= status_d;
        end
    end

    // ************************************************************
    // Interrupt request
    // ************************************************************

    // Level request from registers only, so it cannot glitch; the
    // underflow strobe is combinational and lasts a single cycle
    assign irq_o       = |(status_q & mask_q);
    assign underflow_o = underflow;

    // ************************************************************
    // Read port
    // ************************************************************

    // Read data stand for exactly one cycle after the strobe
    always_comb begin
        rdata_d = tdp_pkg::BYTE_ZERO;
        if (req.rd) begin
            case (req.addr)
                tdp_pkg::ADDR_COUNT:  rdata_d = cnt_q[7:0];
                tdp_pkg::ADDR_CTL1:   rdata_d = ctl1_q;
                tdp_pkg::ADDR_CTL2:   rdata_d = ctl2_q;
                tdp_pkg::ADDR_STATUS: rdata_d = status_q;
                tdp_pkg::ADDR_MASK:   rdata_d = mask_q;
                default:              rdata_d = tdp_pkg::BYTE_ZERO;
            endcase
        end
    end

    // Read data register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= tdp_pkg::BYTE_ZERO;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata_o = rdata_q;

    // ************************************************************
    // PWM output
    // ************************************************************

    // Duty from the low high-bits pair and the duty byte
    assign duty = {high_bits_register_i[tdp_pkg::HB_DUTY_LSB +: 2], pwm_duty_register_i};

    // Period follows the counter, which restarts from the reload, or from CNT_MAX when reload select is off; in one-shot mode it holds at zero
    tdp_pwm #(
        .CNT_W (CNT_W)
    ) u_pwm (
        .clk_i           (clk_i),
        .rst_i           (rst_i),
        .count_i         (cnt_q),
        .duty_i          (duty),
        .polarity_i      (ctl1_q.pwm_polarity_bit),
        .output_enable_i (ctl1_q.pwm_output_enable_bit),
        .gpio_out_i      (gpio_out_i),
        .gpio_oe_n_i     (gpio_oe_n_i),
        .pin_o           (pwm_port_pin_o),
        .pin_oe_n_o      (pwm_port_pin_oe_n_o)
    );

endmodule

// ---- tb/tdp_timer_monitor.sv ----
// Port checker for the ten-bit down timer
`timescale 1ns/1ps
module tdp_timer_monitor #(
    parameter int CNT_W = tdp_pkg::CNT_W
) (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic       instr_tick_i,
    input wire logic       external_clock_pin_i,
    input wire logic [7:0] high_bits_register_i,
    input wire logic [7:0] pwm_duty_register_i,
    input wire logic       gpio_out_i,
    input wire logic       gpio_oe_n_i,
    input wire logic       pwm_port_pin_o,
    input wire logic       pwm_port_pin_oe_n_o,
    input wire logic       underflow_o,
    input wire logic       irq_o
);
    // ****
    // Control shadows
    // ****
    tdp_pkg::tdp_ctl1_t     c1_q, c1_d;
    tdp_pkg::tdp_ctl2_t     c2_q, c2_d;
    logic [CNT_W-1:0]       duty_w;
    // Full duty value as the compare sees it
    assign duty_w = {high_bits_register_i[1:0], pwm_duty_register_i};
    // Follow writes so the checks know the mode; reserved bits stay zero
    always_comb begin
        c1_d = c1_q;
        c2_d = c2_q;
        if (wr_i && addr_i == tdp_pkg::ADDR_CTL1) begin
            c1_d = wdata_i & 8'hC7;
        end
        if (wr_i && addr_i == tdp_pkg::ADDR_CTL2) begin
            c2_d = wdata_i & 8'h3F;
        end
    end
    // Registered copy, cleared like the design
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            c1_q <= tdp_pkg::CTL1_RST;
            c2_q <= tdp_pkg::CTL2_RST;
        end else begin
            c1_q <= c1_d;
            c2_q <= c2_d;
        end
    end
    // ****
    // Assertions
    // ****
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    a_idle_read_zero: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data set outside a read");
    a_ctl_one_readback: assert property ($past(rd_i) && $past(addr_i) == 8'h11 |-> rdata_o == $past(c1_q))
        else $error("control one read back wrong");
    a_unmapped_zero: assert property ($past(rd_i) && $past(addr_i) inside {[8'h13:8'h17]} |-> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_stopped_quiet: assert property (!c1_q.timer_enable_bit |-> !underflow_o)
        else $error("underflow while stopped");
    a_instr_source: assert property (underflow_o && !c2_q.clock_source_bit |-> instr_tick_i)
        else $error("underflow without instruction tick");
    a_fall_edge: assert property (underflow_o && c2_q.clock_source_bit && c2_q.ext_clock_edge_bit
        |-> $fell(external_clock_pin_i))
        else $error("underflow without falling pin edge");
    a_rise_edge: assert property (underflow_o && c2_q.clock_source_bit && !c2_q.ext_clock_edge_bit
        |-> $rose(external_clock_pin_i))
        else $error("underflow without rising pin edge");
    a_one_shot_stop: assert property (underflow_o && c1_q.one_shot_bit && !wr_i |=> !underflow_o)
        else $error("one shot kept counting");
    a_irq_cause: assert property ($rose(irq_o) |-> $past(underflow_o) || $past(underflow_o, 2)
        || $past(wr_i) || $past(wr_i, 2))
        else $error("interrupt rose without cause");
    a_gpio_pass: assert property (!$past(c1_q.pwm_output_enable_bit) |-> pwm_port_pin_o == $past(gpio_out_i)
        && pwm_port_pin_oe_n_o == $past(gpio_oe_n_i))
        else $error("pin not under port control");
    a_pwm_drive: assert property ($past(c1_q.pwm_output_enable_bit) |-> !pwm_port_pin_oe_n_o)
        else $error("pin not driven by pwm");
    a_zero_duty: assert property ($past(c1_q.pwm_output_enable_bit) && $past(duty_w) == 10'h000
        |-> pwm_port_pin_o == $past(c1_q.pwm_polarity_bit))
        else $error("idle pwm level wrong");
endmodule
bind tdp_timer tdp_timer_monitor #(.CNT_W(CNT_W)) u_mon (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .instr_tick_i(instr_tick_i),
    .external_clock_pin_i(external_clock_pin_i), .high_bits_register_i(high_bits_register_i),
    .pwm_duty_register_i(pwm_duty_register_i), .gpio_out_i(gpio_out_i), .gpio_oe_n_i(gpio_oe_n_i),
    .pwm_port_pin_o(pwm_port_pin_o), .pwm_port_pin_oe_n_o(pwm_port_pin_oe_n_o),
    .underflow_o(underflow_o), .irq_o(irq_o));

// ---- tb/tdp_timer_test.sv ----
// Self-checking bench for the ten-bit down timer
`timescale 1ns/1ps
module tdp_timer_test;
    logic        clk_i, rst_i, wr_i, rd_i, tick_on, ext_on, tick_i, ext_i, gp_o, gp_oe_n, pin, pin_oe_n, uf, irq;
    logic [7:0]  addr_i, wdata_i, rdata, hb, duty, rv;
    logic [1:0]  ph;
    logic [31:0] seed;
    int          mismatches, num_checks, p, h;
    logic [7:0]  ra [6] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h18, 8'h19};
    logic [7:0]  re [6] = '{8'h00, 8'h00, 8'h3F, 8'h00, 8'h00, 8'h00};
    int          dw [4] = '{4, 4, 0, 1023};

    tdp_timer DUT (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata), .instr_tick_i(tick_i), .external_clock_pin_i(ext_i), .high_bits_register_i(hb),
        .pwm_duty_register_i(duty), .gpio_out_i(gp_o), .gpio_oe_n_i(gp_oe_n), .pwm_port_pin_o(pin),
        .pwm_port_pin_oe_n_o(pin_oe_n), .underflow_o(uf), .irq_o(irq));

    // ****
    // Clock, sources and helpers
    // ****
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // Pin toggles every two cycles, so each edge kind comes once in four
    always @(posedge clk_i) begin
        tick_i <= tick_on;
        if (ext_on) begin
            ph <= ph + 2'd1;
            ext_i <= ph[1];
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // High cycles in 100 for a period of n+1 ticks, one tick a cycle
    function automatic int highs(input int d, input int n, input logic pol);
        int a;
        a = ((d < n + 1) ? d : n + 1) * 100 / (n + 1);
        return pol ? 100 - a : a;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask
    // One-cycle strobes with a gap, so no strobe is set twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 rv = rdata;
    endtask
    // Cycles up to the next underflow; bounded so a stuck timer cannot hang
    task automatic per(output int n);
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (uf !== 1'b1 && n < 3000);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Watchdog well beyond the longest expected run
    initial begin
        #(5 * 60000);
        mismatches++;
        $display("BAD %0t timeout", $time);
        finish_test();
    end

    // ****
    // Main sequence
    // ****
    initial begin
        {wr_i, rd_i, tick_on, ext_on, tick_i, ext_i, gp_o, ph} = '0;
        {addr_i, wdata_i, hb, duty} = '0;
        gp_oe_n = 1'b1;
        seed = 32'd80;
        rst_i = 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (ra[i]) begin
            rd(ra[i]);
            chk(rv, re[i], "reset value");
        end
        wr(8'h12, 8'hFF);
        wr(8'h13, 8'hFF);
        rd(8'h12);
        chk(rv, 8'h3F, "ctl2 reserved");
        rd(8'h13);
        chk(rv, 8'h00, "unmapped");
        wr(8'h12, 8'h08); // ratio only touched with prescaler off
        tick_on <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            seed = xs(seed);
            @(posedge clk_i);
            hb <= {2'b00, seed[9:8], 4'h0};
            wr(8'h10, seed[7:0]);
            rd(8'h10);
            chk(rv, seed[7:0], "count readback");
            wr(8'h11, 8'h03);
            per(p);
            per(p);
            chk(p, seed[9:0] + 1, "reload period");
            wr(8'h11, 8'h00);
            rd(8'h10);
            p = rv;
            repeat (5) @(posedge clk_i);
            rd(8'h10);
            chk(rv, p, "stopped count");
        end
        @(posedge clk_i);
        hb <= 8'h00;
        wr(8'h10, 8'h01);
        wr(8'h11, 8'h01);
        per(p);
        per(p);
        chk(p, 1024, "free run period");
        wr(8'h11, 8'h03);
        for (int r = 0; r < 8; r++) begin
            wr(8'h12, 8'h08 | r[7:0]); // new ratio while prescaler off
            wr(8'h12, r[7:0]);
            per(p);
            per(p);
            chk(p, 2 << (r + 1), "prescaled period");
        end
        ext_on <= 1'b1;
        for (int e = 0; e < 2; e++) begin
            wr(8'h12, {3'b001, e[0], 4'h8});
            per(p);
            per(p);
            chk(p, 8, "pin edge period");
            chk(ext_i, !e[0], "edge kind");
        end
        ext_on <= 1'b0;
        wr(8'h12, 8'h08);
        wr(8'h11, 8'h00);
        wr(8'h19, 8'h01);
        wr(8'h18, 8'h01);
        repeat (2) @(negedge clk_i);
        chk(irq, 1'b0, "irq cleared");
        wr(8'h10, 8'h03);
        wr(8'h11, 8'h07);
        per(p);
        per(p);
        chk(p, 3000, "one shot stops");
        rd(8'h10);
        chk(rv, 8'h00, "one shot rests at zero");
        chk(irq, 1'b1, "irq on underflow");
        wr(8'h18, 8'h01);
        repeat (2) @(negedge clk_i);
        chk(irq, 1'b0, "irq write one clears");
        wr(8'h10, 8'h03);
        per(p);
        wr(8'h19, 8'h00);
        repeat (2) @(negedge clk_i);
        chk(irq, 1'b0, "irq masked");
        rd(8'h18);
        chk(rv, 8'h01, "status sticky");
        wr(8'h10, 8'h09);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_i);
            hb <= {6'h00, dw[k][9:8]};
            duty <= dw[k][7:0];
            wr(8'h11, k == 1 ? 8'hC3 : 8'h83);
            repeat (20) @(negedge clk_i);
            h = 0;
            repeat (100) begin
                @(negedge clk_i);
                h += (pin === 1'b1);
            end
            chk(h, highs(dw[k], 9, k == 1), "pwm high count");
            chk(pin_oe_n, 1'b0, "pin driven");
        end
        wr(8'h11, 8'hFB);
        rd(8'h11);
        chk(rv, 8'hC3, "ctl1 reserved");
        wr(8'h11, 8'h00);
        repeat (20) begin
            @(posedge clk_i);
            gp_o <= seed[0];
            gp_oe_n <= seed[1];
            @(posedge clk_i);
            #1 chk({pin, pin_oe_n}, {seed[0], seed[1]}, "port control");
            seed = xs(seed);
        end
        finish_test();
    end
endmodule
